/* common/tstu_consts.svh */
`ifndef TSTU_CONSTS_SVH
`define TSTU_CONSTS_SVH

// Widths
`define TSTU_NUM_CH          4
`define TSTU_CH_SEL_W        2
`define TSTU_TS_W            64
`define TSTU_CNT_W           32
`define TSTU_LEN_W           16
`define TSTU_OFS_W           24
`define TSTU_DIV_W           8

// Time unit is 125 ps; the Data Clock runs at 250 MHz (4000 ps)
`define TSTU_TIME_UNIT_PS    125
`define TSTU_CLK_PERIOD_PS   4000
`define TSTU_UNITS_PER_CLK   (`TSTU_CLK_PERIOD_PS / `TSTU_TIME_UNIT_PS)

// Reset values
`define TSTU_TS_RST          64'h0
`define TSTU_CNT_RST         32'h0

`endif

/* common/tstu_pkg.sv */
package tstu_pkg;

  // Active trigger type
  typedef enum logic [5:0] {
    TSTU_SRC_LEVEL    = 6'h01,
    TSTU_SRC_PERIODIC = 6'h02,
    TSTU_SRC_SOFTWARE = 6'h04,
    TSTU_SRC_BACKPL   = 6'h08,
    TSTU_SRC_FRONT    = 6'h10,
    TSTU_SRC_SYNC     = 6'h20
  } tstu_src_e;

  // Timestamp reset mode
  typedef enum logic [1:0] {
    TSTU_RMODE_REPEAT = 2'h0,
    TSTU_RMODE_SINGLE = 2'h1
  } tstu_rmode_e;

  // Timestamp reset arm state
  typedef enum logic [2:0] {
    TSTU_RS_DISARMED = 3'h1,
    TSTU_RS_ARMED    = 3'h2,
    TSTU_RS_DONE     = 3'h4
  } tstu_rst_state_e;

endpackage

/* rtl/tstu_trigger_timestamp_unit.sv */
`timescale 1ns/100ps
`include "tstu_consts.svh"
// Functional notes
// RQ1: One level detector per input; software picks which channel's detector triggers.
// RQ2: Software selects exactly one active trigger source from six types.
// RQ3: Software fire command is a pulse and one selectable trigger source.
// RQ4: Trigger output enabled makes the front connector unusable as trigger input.
// RQ5: Selected triggers pass a blocking gate before reaching acquisition.
// RQ6: Only software-selected channels contribute data to records.
// RQ7: Frame grouping counts accepted triggers into groups set by software.
// RQ8: Pretrigger lets a record start a programmable number of samples early.
// RQ9: Trigger delay holds record start off by programmed samples.
// RQ10: Trigger time, start offset and sample interval reported in 125 ps units.
// RQ11: Start offset negative with pretrigger, positive with trigger delay.
// RQ12: Sample interval follows sample skip and sampling clock setting.
// RQ13: Timestamp counter runs on the internal clock from the selected reference.
// RQ14: Captured timestamp equals time since latest counter start or reset.
// RQ15: Counter cleared at power-up; no external reset while disarmed.
// RQ16: Reset source selectable from front trigger, sync or other sources.
// RQ17: Software disarms, then sets source and mode, then arms.
// RQ18: Repeating mode clears counter on every selected source pulse.
// RQ19: Single mode clears counter on first pulse only, ignores later ones.
// RQ20: Reset pulses counted, stored in record header and readable.
// RQ21: Front trigger reset has sample resolution; sync and backplane clock resolution.
// RQ22: Data Clock is the 250 MHz processing clock.
// RQ23: Accepted reset loads zero, counting resumes on the next cycle.
module tstu_trigger_timestamp_unit (
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  // Trigger inputs
  input  wire logic [`TSTU_NUM_CH-1:0]       level_hit_i,
  input  wire logic                          software_fire_cmd_i,
  input  wire logic                          backplane_front_trigger_connector_i,
  input  wire logic                          front_trigger_connector_i,
  input  wire logic [2:0]                    front_front_trigger_connector_subsample_i,
  input  wire logic                          sync_in_i,
  // Trigger selection and output
  input  wire logic [`TSTU_CH_SEL_W-1:0]     level_channel_sel_i,
  input  wire tstu_pkg::tstu_src_e           trigger_source_select_cmd_i,
  input  wire logic                          trigger_out_enable_cmd_i,
  input  wire logic [`TSTU_DIV_W-1:0]        periodic_period_i,
  output logic                               front_trigger_connector_o,
  output logic                               front_trigger_connector_oe_o,
  // Blocking, grouping and channels
  input  wire logic                          trigger_gate_open_i,
  input  wire logic [`TSTU_LEN_W-1:0]        frame_group_size_i,
  input  wire logic [`TSTU_NUM_CH-1:0]       channel_select_cmd_i,
  output logic [`TSTU_NUM_CH-1:0]            record_channels_o,
  output logic [`TSTU_LEN_W-1:0]             frame_index_o,
  // Trigger position
  input  wire logic [`TSTU_LEN_W-1:0]        pretrigger_length_cmd_i,
  input  wire logic [`TSTU_LEN_W-1:0]        trigger_delay_cmd_i,
  input  wire logic [`TSTU_DIV_W-1:0]        sample_skip_i,
  input  wire logic [`TSTU_DIV_W-1:0]        units_per_sample_i,
  // Timestamp reset control
  input  wire logic                          time_reset_disarm_cmd_i,
  input  wire logic                          time_reset_setup_cmd_i,
  input  wire logic                          time_reset_arm_cmd_i,
  input  wire tstu_pkg::tstu_src_e           time_reset_src_i,
  input  wire tstu_pkg::tstu_rmode_e         time_reset_mode_i,
  // Accept and start strobes, record header and live counters
  output logic                               front_trigger_connector_accept_o,
  output logic                               record_start_o,
  output logic [`TSTU_TS_W-1:0]              time_stamp_o,
  output logic signed [`TSTU_OFS_W-1:0]      record_start_ofs_o,
  output logic [`TSTU_OFS_W-1:0]             sample_period_o,
  output logic [`TSTU_CNT_W-1:0]             header_reset_count_o,
  output logic [`TSTU_CNT_W-1:0]             reset_pulse_count_read_o,
  output logic [`TSTU_TS_W-1:0]              time_unit_count_o
);
  import tstu_pkg::*;

  logic [`TSTU_DIV_W-1:0]        per_cnt_q;
  logic                          per_pulse;
  logic                          level_sel;
  logic                          front_in;
  logic                          front_trigger_connector_sel;
  logic                          front_trigger_connector_prev_q;
  logic                          front_trigger_connector_edge;
  logic                          accept;
  logic [`TSTU_LEN_W-1:0]        grp_cnt_q;
  logic [`TSTU_LEN_W-1:0]        delay_cnt_q;
  logic                          delay_run_q;
  logic [`TSTU_TS_W-1:0]         ts_q;
  logic [`TSTU_CNT_W-1:0]        rst_cnt_q;
  tstu_rst_state_e               rs_q;
  tstu_src_e                     rsrc_q;
  tstu_rmode_e                   rmode_q;
  logic                          rsrc_sig;
  logic                          rsrc_prev_q;
  logic                          rsrc_edge;
  logic                          take_reset;
  logic [`TSTU_TS_W-1:0]         sub_ofs;
  logic [`TSTU_OFS_W-1:0]        spp;
  logic [`TSTU_NUM_CH-1:0]       lvl_prev_q;
  logic [`TSTU_NUM_CH-1:0]       lvl_edge;
  logic                          grp_wrap;
  logic [`TSTU_DIV_W-1:0]        skip_eff;
  logic signed [`TSTU_OFS_W-1:0] start_ofs;

  // Internal periodic generator
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || per_pulse) begin
      per_cnt_q <= 8'h00;
    end else begin
      per_cnt_q <= per_cnt_q + 8'h01;
    end
  end
  assign per_pulse = (per_cnt_q >= periodic_period_i);

  // One detector per input: a hit counts on its rising edge only
  for (genvar ch = 0; ch < `TSTU_NUM_CH; ch++) begin : g_lvl
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        lvl_prev_q[ch] <= 1'b0;
      end else begin
        lvl_prev_q[ch] <= level_hit_i[ch];
      end
    end
    assign lvl_edge[ch] = level_hit_i[ch] & ~lvl_prev_q[ch]; // RQ1
  end
  assign level_sel = lvl_edge[level_channel_sel_i]; // RQ1

  // Connector is ours while driving, so its input is ignored
  assign front_in  = front_trigger_connector_i & ~trigger_out_enable_cmd_i; // RQ4

  always_comb begin
    unique case (trigger_source_select_cmd_i) // RQ2
      TSTU_SRC_LEVEL:    front_trigger_connector_sel = level_sel;
      TSTU_SRC_PERIODIC: front_trigger_connector_sel = per_pulse;
      TSTU_SRC_SOFTWARE: front_trigger_connector_sel = software_fire_cmd_i; // RQ3
      TSTU_SRC_BACKPL:   front_trigger_connector_sel = backplane_front_trigger_connector_i;
      TSTU_SRC_FRONT:    front_trigger_connector_sel = front_in;
      TSTU_SRC_SYNC:     front_trigger_connector_sel = sync_in_i;
      default:           front_trigger_connector_sel = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      front_trigger_connector_prev_q <= 1'b0;
    end else begin
      front_trigger_connector_prev_q <= front_trigger_connector_sel;
    end
  end
  assign front_trigger_connector_edge = front_trigger_connector_sel & ~front_trigger_connector_prev_q;
  assign accept    = front_trigger_connector_edge & trigger_gate_open_i; // RQ5

  // Trigger output drives the connector with the selected trigger, and low while the front connector is the source
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      front_trigger_connector_o <= 1'b0;
    end else begin
      front_trigger_connector_o <= front_trigger_connector_sel & (trigger_source_select_cmd_i != TSTU_SRC_FRONT);
    end
  end

  // Driver enable follows the command one cycle later
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      front_trigger_connector_oe_o <= 1'b0;
    end else begin
      front_trigger_connector_oe_o <= trigger_out_enable_cmd_i; // RQ4
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      record_channels_o <= '0;
    end else begin
      record_channels_o <= channel_select_cmd_i; // RQ6
    end
  end

  // Size zero means no group wrap; the index only rolls over at its 16-bit limit
  assign grp_wrap = (frame_group_size_i != 16'h0000) &&
                    (grp_cnt_q >= frame_group_size_i - 16'h0001);

  // Frame grouping: index within current group, wraps at group size
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      grp_cnt_q <= 16'h0000;
    end else if (accept) begin
      if (grp_wrap) begin
        grp_cnt_q <= 16'h0000; // RQ7
      end else begin
        grp_cnt_q <= grp_cnt_q + 16'h0001; // RQ7
      end
    end
  end
  assign frame_index_o = grp_cnt_q;

  // Source and mode are only taken while disarmed, so an armed unit
  // cannot change what resets its counter
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rsrc_q  <= TSTU_SRC_FRONT;
      rmode_q <= TSTU_RMODE_REPEAT;
    end else if (time_reset_setup_cmd_i && rs_q == TSTU_RS_DISARMED) begin
      rsrc_q  <= time_reset_src_i; // RQ16
      rmode_q <= time_reset_mode_i; // RQ17
    end
  end

  // Timestamp reset arm state machine; disarm wins over a same-cycle arm
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rs_q <= TSTU_RS_DISARMED;
    end else if (time_reset_disarm_cmd_i) begin
      rs_q <= TSTU_RS_DISARMED; // RQ17
    end else begin
      unique case (rs_q)
        TSTU_RS_DISARMED: begin
          if (time_reset_arm_cmd_i) begin
            rs_q <= TSTU_RS_ARMED; // RQ17
          end
        end
        TSTU_RS_ARMED: begin
          if (take_reset && rmode_q == TSTU_RMODE_SINGLE) begin
            rs_q <= TSTU_RS_DONE; // RQ19
          end
        end
        TSTU_RS_DONE: begin
          rs_q <= TSTU_RS_DONE;
        end
        default: begin
          rs_q <= TSTU_RS_DISARMED;
        end
      endcase
    end
  end

  always_comb begin
    unique case (rsrc_q) // RQ16
      TSTU_SRC_LEVEL:    rsrc_sig = level_sel;
      TSTU_SRC_PERIODIC: rsrc_sig = per_pulse;
      TSTU_SRC_SOFTWARE: rsrc_sig = software_fire_cmd_i;
      TSTU_SRC_BACKPL:   rsrc_sig = backplane_front_trigger_connector_i;
      TSTU_SRC_FRONT:    rsrc_sig = front_in;
      TSTU_SRC_SYNC:     rsrc_sig = sync_in_i;
      default:           rsrc_sig = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rsrc_prev_q <= 1'b0;
    end else begin
      rsrc_prev_q <= rsrc_sig;
    end
  end
  assign rsrc_edge  = rsrc_sig & ~rsrc_prev_q;
  // Only while armed; disarmed and single-done states ignore pulses
  assign take_reset = rsrc_edge & (rs_q == TSTU_RS_ARMED); // RQ15 RQ18 RQ19

  // Front trigger carries a sub-cycle phase; sync/backplane only clock resolution
  assign sub_ofs = (rsrc_q == TSTU_SRC_FRONT) ?
                   {61'h0, front_front_trigger_connector_subsample_i} : `TSTU_TS_RST; // RQ21

  // Timestamp counter on the 250 MHz Data Clock, in 125 ps units
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ts_q <= `TSTU_TS_RST; // RQ15
    end else if (take_reset) begin
      ts_q <= `TSTU_TS_RST; // RQ23
    end else begin
      ts_q <= ts_q + 64'(`TSTU_UNITS_PER_CLK); // RQ13 RQ22
    end
  end
  assign time_unit_count_o = ts_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rst_cnt_q <= `TSTU_CNT_RST;
    end else if (take_reset) begin
      rst_cnt_q <= rst_cnt_q + 32'h1; // RQ20
    end
  end
  assign reset_pulse_count_read_o = rst_cnt_q; // RQ20

  // Sample interval scales with skip and sampling clock; a skip of zero acts as one
  assign skip_eff = (sample_skip_i == 8'h00) ? 8'h01 : sample_skip_i;
  assign spp      = 24'(units_per_sample_i) * 24'(skip_eff); // RQ12

  // Delay wins when both are programmed, so the offset then points forward
  always_comb begin
    if (trigger_delay_cmd_i != 16'h0000) begin
      start_ofs = signed'(24'(trigger_delay_cmd_i) * spp); // RQ11
    end else begin
      start_ofs = -signed'(24'(pretrigger_length_cmd_i) * spp); // RQ11
    end
  end

  // Trigger delay holdoff; a new accept during a holdoff restarts it,
  // so a burst of triggers yields a single record start
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      delay_cnt_q    <= 16'h0000;
      delay_run_q    <= 1'b0;
      record_start_o <= 1'b0;
    end else begin
      record_start_o <= 1'b0;
      if (accept) begin
        if (trigger_delay_cmd_i == 16'h0000) begin
          record_start_o <= 1'b1; // RQ8
        end else begin
          delay_run_q <= 1'b1;
          delay_cnt_q <= trigger_delay_cmd_i - 16'h0001;
        end
      end else if (delay_run_q) begin
        if (delay_cnt_q == 16'h0000) begin
          delay_run_q    <= 1'b0;
          record_start_o <= 1'b1; // RQ9
        end else begin
          delay_cnt_q <= delay_cnt_q - 16'h0001;
        end
      end
    end
  end

  // Accept strobe, one cycle after the qualified edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      front_trigger_connector_accept_o <= 1'b0;
    end else begin
      front_trigger_connector_accept_o <= accept; // RQ5
    end
  end

  // Header fields hold until the next accepted trigger
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      time_stamp_o         <= `TSTU_TS_RST;
      record_start_ofs_o   <= '0;
      sample_period_o      <= '0;
      header_reset_count_o <= `TSTU_CNT_RST;
    end else if (accept) begin
      time_stamp_o         <= ts_q + sub_ofs; // RQ14 RQ10
      record_start_ofs_o   <= start_ofs; // RQ11
      sample_period_o      <= spp; // RQ12
      header_reset_count_o <= rst_cnt_q; // RQ20
    end
  end

endmodule

/* tb/tstu_monitor.sv */
`timescale 1ns/100ps
module tstu_monitor (
  // Clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  // Watched inputs
  input wire logic              software_fire_cmd_i,
  input wire logic              trigger_gate_open_i,
  input wire logic              trigger_out_enable_cmd_i,
  input wire tstu_pkg::tstu_src_e trigger_source_select_cmd_i,
  input wire logic [15:0]       trigger_delay_cmd_i,
  // Watched outputs
  input wire logic              front_trigger_connector_accept_o,
  input wire logic              record_start_o,
  input wire logic              front_trigger_connector_oe_o,
  input wire logic [31:0]       reset_pulse_count_read_o,
  input wire logic [63:0]       time_unit_count_o
);
  import tstu_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_ts_step;
    !$past(rst_i) |-> time_unit_count_o == $past(time_unit_count_o) + 64'h20
      || time_unit_count_o == 64'h0;
  endproperty
  a_ts_step: assert property (p_ts_step) else $error("time count step wrong");
  property p_cnt_step;
    !$past(rst_i) && $changed(reset_pulse_count_read_o)
      |-> reset_pulse_count_read_o == $past(reset_pulse_count_read_o) + 32'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("pulse count jump");
  property p_zero_run;
    !$past(rst_i) && $changed(reset_pulse_count_read_o)
      |-> time_unit_count_o == 64'h0 ##1 time_unit_count_o == 64'h20;
  endproperty
  a_zero_run: assert property (p_zero_run) else $error("counter not restarted");
  property p_acc_pulse;
    front_trigger_connector_accept_o |=> !front_trigger_connector_accept_o;
  endproperty
  a_acc_pulse: assert property (p_acc_pulse) else $error("accept too long");
  property p_oe;
    !$past(rst_i) |-> front_trigger_connector_oe_o == $past(trigger_out_enable_cmd_i);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_gate;
    !trigger_gate_open_i |=> !front_trigger_connector_accept_o;
  endproperty
  a_gate: assert property (p_gate) else $error("accept with gate closed");
  property p_sw;
    trigger_source_select_cmd_i == TSTU_SRC_SOFTWARE && trigger_gate_open_i
      && $rose(software_fire_cmd_i) |=> front_trigger_connector_accept_o;
  endproperty
  a_sw: assert property (p_sw) else $error("software fire lost");
  property p_nodly;
    front_trigger_connector_accept_o && $past(trigger_delay_cmd_i) == 16'h0 |-> record_start_o;
  endproperty
  a_nodly: assert property (p_nodly) else $error("start not immediate");
  property p_dly;
    front_trigger_connector_accept_o && $past(trigger_delay_cmd_i) == 16'h3
      |-> !record_start_o [*3] ##1 record_start_o;
  endproperty
  a_dly: assert property (p_dly) else $error("delayed start wrong");
endmodule
bind tstu_trigger_timestamp_unit tstu_monitor mon (.*);

/* tb/tstu_src_model.sv */
`timescale 1ns/100ps
module tstu_src_model (
  // Clock and direction
  input  wire logic sys_clk_i,
  input  wire logic oe_i,
  // Event lines
  output logic      backplane_o,
  output logic      front_o,
  output logic      sync_o
);
  logic [2:0] lines = 3'h0;
  assign {sync_o, front_o, backplane_o} = lines;
  // One-cycle pulse; front stays quiet while the unit owns the connector
  task automatic pulse(input int idx);
    @(negedge sys_clk_i);
    if (!(idx == 1 && oe_i)) lines[idx] = 1'b1;
    @(negedge sys_clk_i);
    lines = 3'h0;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import tstu_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, software_fire_cmd_i = 0, trigger_gate_open_i = 1;
  logic trigger_out_enable_cmd_i = 0, backplane_front_trigger_connector_i, front_trigger_connector_i, sync_in_i;
  logic time_reset_disarm_cmd_i = 0, time_reset_setup_cmd_i = 0, time_reset_arm_cmd_i = 0;
  logic [3:0] level_hit_i = 4'h0, channel_select_cmd_i = 4'h5, record_channels_o;
  logic [1:0] level_channel_sel_i = 2'h2;
  logic [2:0] front_front_trigger_connector_subsample_i = 3'h0;
  logic [7:0] periodic_period_i = 8'h3, sample_skip_i = 8'h1, units_per_sample_i = 8'h8;
  logic [15:0] frame_group_size_i = 0, pretrigger_length_cmd_i = 0, trigger_delay_cmd_i = 0;
  logic [15:0] frame_index_o;
  tstu_src_e trigger_source_select_cmd_i = TSTU_SRC_LEVEL, time_reset_src_i = TSTU_SRC_SYNC;
  tstu_rmode_e time_reset_mode_i = TSTU_RMODE_REPEAT;
  logic front_trigger_connector_o, front_trigger_connector_oe_o, front_trigger_connector_accept_o, record_start_o;
  logic [63:0] time_stamp_o, time_unit_count_o, ts;
  logic signed [23:0] record_start_ofs_o;
  logic [23:0] sample_period_o;
  logic [31:0] header_reset_count_o, reset_pulse_count_read_o, n;
  int failures = 0, tests_run = 0;
  tstu_trigger_timestamp_unit uut (.*);
  tstu_src_model src (.sys_clk_i, .oe_i(front_trigger_connector_oe_o),
    .backplane_o(backplane_front_trigger_connector_i), .front_o(front_trigger_connector_i), .sync_o(sync_in_i));
  always #2 sys_clk_i = ~sys_clk_i;
  task automatic check(input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Checks the current cycle first: pulse helpers return with the accept showing
  task automatic wait_accept();
    for (int i = 0; i < 12; i++) begin
      if (front_trigger_connector_accept_o === 1'b1) return;
      @(negedge sys_clk_i);
    end
    failures++;
    give_verdict();
  endtask
  task automatic fire();
    @(negedge sys_clk_i) software_fire_cmd_i = 1;
    @(negedge sys_clk_i) software_fire_cmd_i = 0;
    wait_accept();
  endtask
  task automatic t_sources();
    tstu_src_e s[3] = '{TSTU_SRC_BACKPL, TSTU_SRC_FRONT, TSTU_SRC_SYNC};
    ts = time_unit_count_o;
    @(negedge sys_clk_i) level_hit_i = 4'h2;
    check(time_unit_count_o - ts, 64'h20);
    @(negedge sys_clk_i) level_hit_i = 4'h4;
    check(front_trigger_connector_accept_o, 0);
    ts = time_unit_count_o;
    @(negedge sys_clk_i) level_hit_i = 4'h0;
    wait_accept();
    check(time_stamp_o, ts);
    trigger_source_select_cmd_i = TSTU_SRC_SOFTWARE;
    fire();
    for (int k = 0; k < 3; k++) begin
      @(negedge sys_clk_i) trigger_source_select_cmd_i = s[k];
      src.pulse(k);
      wait_accept();
    end
    trigger_source_select_cmd_i = TSTU_SRC_PERIODIC;
    @(negedge sys_clk_i);
    wait_accept();
  endtask
  task automatic t_position();
    @(negedge sys_clk_i) trigger_source_select_cmd_i = TSTU_SRC_SOFTWARE;
    sample_skip_i = 8'h2;
    pretrigger_length_cmd_i = 16'h10;
    fire();
    check(record_start_o, 1);
    check({40'h0, record_start_ofs_o}, 64'hffff00);
    check(sample_period_o, 16);
    trigger_delay_cmd_i = 16'h3;
    fire();
    check({40'h0, record_start_ofs_o}, 64'h30);
    repeat (3) @(negedge sys_clk_i);
    check(record_start_o, 1);
    trigger_delay_cmd_i = 16'h0;
  endtask
  task automatic ts_cmd(input tstu_rmode_e m, input tstu_src_e s);
    @(negedge sys_clk_i) time_reset_disarm_cmd_i = 1;
    @(negedge sys_clk_i) time_reset_disarm_cmd_i = 0;
    time_reset_mode_i = m;
    time_reset_src_i = s;
    time_reset_setup_cmd_i = 1;
    @(negedge sys_clk_i) time_reset_setup_cmd_i = 0;
    time_reset_arm_cmd_i = 1;
    @(negedge sys_clk_i) time_reset_arm_cmd_i = 0;
  endtask
  task automatic t_tsreset();
    n = reset_pulse_count_read_o;
    src.pulse(1);
    check(reset_pulse_count_read_o, n);
    ts_cmd(TSTU_RMODE_REPEAT, TSTU_SRC_SYNC);
    repeat (2) begin
      src.pulse(2);
      check(time_unit_count_o, 0);
      @(negedge sys_clk_i) check(time_unit_count_o, 32);
    end
    ts_cmd(TSTU_RMODE_SINGLE, TSTU_SRC_FRONT);
    src.pulse(1);
    check(time_unit_count_o, 0);
    src.pulse(1);
    check(time_unit_count_o == 0, 0);
    check(reset_pulse_count_read_o, n + 3);
    front_front_trigger_connector_subsample_i = 3'h5;
    fire();
    check(header_reset_count_o, n + 3);
    check(time_unit_count_o - time_stamp_o, 64'h1b);
  endtask
  task automatic t_misc();
    @(negedge sys_clk_i) trigger_gate_open_i = 0;
    software_fire_cmd_i = 1;
    repeat (3) @(negedge sys_clk_i) check(front_trigger_connector_accept_o, 0);
    software_fire_cmd_i = 0;
    trigger_gate_open_i = 1;
    trigger_out_enable_cmd_i = 1;
    repeat (2) @(negedge sys_clk_i);
    check(front_trigger_connector_oe_o, 1);
    check(record_channels_o, 4'h5);
    frame_group_size_i = 16'h2;
    fire();
    check(front_trigger_connector_o, 1);
    check(frame_index_o, 0);
    fire();
    check(frame_index_o, 1);
    fire();
    check(frame_index_o, 0);
    trigger_out_enable_cmd_i = 0;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk_i);
    rst_i = 0;
    @(negedge sys_clk_i);
    t_sources();
    t_position();
    t_tsreset();
    t_misc();
    give_verdict();
  end
endmodule
